// file: verilog/uef_pkg.sv
/*
 Shared constants and carriers for the USB event flag block.
 Assumes a 20 MHz system clock and a classic Wishbone register bus.
*/
package uef_pkg;
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int REG_W = 8;
   localparam int FRAME_W = 16;
   // Register offsets (byte addresses)
   localparam logic [ADR_W-1:0] OFS_FLAGS = 8'h00;
   localparam logic [ADR_W-1:0] OFS_MASK = 8'h04;
   localparam logic [ADR_W-1:0] OFS_THR = 8'h08;
   localparam logic [ADR_W-1:0] OFS_PTR = 8'h0C;
   localparam logic [ADR_W-1:0] OFS_CTL = 8'h10;
   localparam logic [ADR_W-1:0] OFS_TOK = 8'h14;
   localparam logic [ADR_W-1:0] OFS_ERRST = 8'h18;
   localparam logic [ADR_W-1:0] OFS_ERREN = 8'h1C;
   // Event flag bit positions
   localparam int BIT_STALL = 7;
   localparam int BIT_ATTACH = 6;
   localparam int BIT_RESUME = 5;
   localparam int BIT_IDLE = 4;
   localparam int BIT_TOKEN = 3;
   localparam int BIT_FRAME = 2;
   localparam int BIT_ERR = 1;
   localparam int BIT_RST = 0;
   localparam int BIT_HOST = 0;
   localparam logic [REG_W-1:0] RST_VAL = 8'h00;
   localparam logic [REG_W-1:0] PTR_MASK = 8'hFE;
   localparam logic [REG_W-1:0] ERRBIT_MASK = 8'h02;
   // Line states as {dPlus, dMinus}
   localparam logic [1:0] LS_SE0 = 2'h0;
   localparam logic [1:0] LS_K = 2'h1;
   localparam logic [1:0] LS_J = 2'h2;
   // Timing
   localparam int CLK_NS = 50;
   localparam int LINE_T_NS = 2500;
   localparam int IDLE_T_US = 3000;
   localparam int LINE_CYC = (LINE_T_NS + CLK_NS - 1) / CLK_NS;
   localparam int IDLE_CYC = (IDLE_T_US * 1000) / CLK_NS;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [ADR_W-1:0] adr;
      logic [DAT_W-1:0] dat;
   } uef_wbreq_s;

   typedef struct packed {
      logic [3:0] ep;
      logic dir;
      logic odd;
   } uef_tok_s;
endpackage

// file: verilog/uef_top.sv
/*
 USB event flags, frame-start threshold, descriptor table pointer and
 token status queue, with a classic Wishbone slave and one interrupt.
 Assumes event inputs are one-cycle pulses synchronous to clk and the
 line state is already sampled into the clk domain.
*/
`timescale 1ns/1ns
module uef_top #(
   parameter int IDLE_CYCLES = uef_pkg::IDLE_CYC,
   parameter int TOK_DEPTH = 4,
   parameter int ERR_W = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire uef_pkg::uef_wbreq_s wbReq,
   output logic wbAck,
   output logic [uef_pkg::DAT_W-1:0] wbDatOut,
   output logic irq,
   input wire logic [1:0] lineState,
   input wire logic stallHs,
   input wire logic tokenDone,
   input wire uef_pkg::uef_tok_s tokenInfo,
   output logic tokenFull,
   input wire logic sofRx,
   input wire logic [uef_pkg::FRAME_W-1:0] frameLeft,
   input wire logic [ERR_W-1:0] errEvent,
   output logic hostModeEnable,
   output logic [6:0] descTableBaseBits
);
   import uef_pkg::*;

   localparam int CW = $clog2(IDLE_CYCLES + 1);
   localparam int PW = (TOK_DEPTH > 1) ? $clog2(TOK_DEPTH) : 1;
   localparam logic [CW-1:0] LINE_LIM = CW'(LINE_CYC);
   localparam logic [CW-1:0] IDLE_LIM = CW'(IDLE_CYCLES);
   localparam logic [PW:0] TOK_FULL = (PW + 1)'(TOK_DEPTH);

   function automatic logic [CW-1:0] stepCnt(input logic run, input logic [CW-1:0] cnt,
                                            input logic [CW-1:0] lim);
      if (!run)
         stepCnt = '0;
      else if (cnt >= lim)
         stepCnt = cnt;
      else
         stepCnt = cnt + 1'b1;
   endfunction

   function automatic logic cntHit(input logic run, input logic [CW-1:0] cnt,
                                   input logic [CW-1:0] lim);
      cntHit = run && (cnt == lim - 1'b1);
   endfunction

   logic ack_q;
   logic [DAT_W-1:0] datOut_q;
   logic irq_q;
   logic [REG_W-1:0] flags_q;
   logic [REG_W-1:0] mask_q;
   logic [REG_W-1:0] thr_q;
   logic [REG_W-1:0] ptr_q;
   logic hostMode_q;
   logic [ERR_W-1:0] errStat_q;
   logic [ERR_W-1:0] errEn_q;
   logic [1:0] lsPrev_q;
   logic [CW-1:0] quietCnt_q;
   logic [CW-1:0] kCnt_q;
   logic [CW-1:0] idleCnt_q;
   logic [CW-1:0] se0Cnt_q;
   logic attached_q;
   logic matchPrev_q;
   uef_tok_s tokMem [TOK_DEPTH];
   logic [PW-1:0] wrPtr_q;
   logic [PW-1:0] rdPtr_q;
   logic [PW:0] tokCount_q;
   logic tokFull_q;

   // Bus decode
   wire reqOn = wbReq.cyc & wbReq.stb;
   wire ack_d = reqOn & ~ack_q;
   wire wrOn = reqOn & ack_q & wbReq.we & wbReq.sel[0];
   wire [REG_W-1:0] wd = wbReq.dat[REG_W-1:0];
   wire wrFlags = wrOn && (wbReq.adr == OFS_FLAGS);
   wire wrMask = wrOn && (wbReq.adr == OFS_MASK);
   wire wrThr = wrOn && (wbReq.adr == OFS_THR);
   wire wrPtr = wrOn && (wbReq.adr == OFS_PTR);
   wire wrCtl = wrOn && (wbReq.adr == OFS_CTL);
   wire wrErrSt = wrOn && (wbReq.adr == OFS_ERRST);
   wire wrErrEn = wrOn && (wbReq.adr == OFS_ERREN);
   wire [REG_W-1:0] flagClr = wrFlags ? (wd & ~ERRBIT_MASK) : RST_VAL;
   wire [ERR_W-1:0] errClr = wrErrSt ? ERR_W'(wd) : '0;

   // Line monitors
   wire lsChanged = lineState != lsPrev_q;
   wire isSe0 = lineState == LS_SE0;
   wire isK = lineState == LS_K;
   wire isJ = lineState == LS_J;
   wire quietHit = cntHit(~lsChanged, quietCnt_q, LINE_LIM);
   wire resumeHit = cntHit(isK, kCnt_q, LINE_LIM);
   wire idleHit = cntHit(isJ, idleCnt_q, IDLE_LIM);
   wire se0Hit = cntHit(isSe0, se0Cnt_q, LINE_LIM);
   wire attachHit = hostMode_q & quietHit & ~isSe0 & ~attached_q;
   wire detachHit = hostMode_q & attached_q & se0Hit;
   wire busRstHit = ~hostMode_q & se0Hit;
   wire attached_d = hostMode_q & ((attached_q & ~detachHit) | attachHit);

   // Frame start
   wire thrMatch = hostMode_q && (frameLeft == FRAME_W'(thr_q));
   wire sofSet = (~hostMode_q & sofRx) | (thrMatch & ~matchPrev_q);

   // Token status queue
   wire tokPop = flagClr[BIT_TOKEN] & flags_q[BIT_TOKEN] & (tokCount_q != '0);
   wire tokPush = tokenDone & (tokCount_q != TOK_FULL);
   wire [PW:0] tokCount_d = tokCount_q + (PW + 1)'(tokPush) - (PW + 1)'(tokPop);
   wire tokSet = (tokCount_d != '0) && (tokPop || tokCount_q == '0);
   wire [REG_W-1:0] tokView = (tokCount_q == '0) ? RST_VAL : {tokMem[rdPtr_q], 2'h0};

   // Error summary
   wire [ERR_W-1:0] errStat_d = (errStat_q & ~errClr) | errEvent;
   wire errSum = |(errStat_q & errEn_q);

   logic [REG_W-1:0] flagSet;
   always_comb begin
      flagSet = RST_VAL;
      flagSet[BIT_STALL] = stallHs;
      flagSet[BIT_ATTACH] = attachHit;
      flagSet[BIT_RESUME] = resumeHit;
      flagSet[BIT_IDLE] = idleHit;
      flagSet[BIT_TOKEN] = tokSet;
      flagSet[BIT_FRAME] = sofSet;
      flagSet[BIT_RST] = busRstHit | detachHit;
   end

   wire [REG_W-1:0] flags_d = (flags_q & ~flagClr) | flagSet;
   wire [REG_W-1:0] flagView = (flags_q & ~ERRBIT_MASK) | (errSum ? ERRBIT_MASK : RST_VAL);
   wire irq_d = |(flagView & mask_q);

   logic [REG_W-1:0] rdByte;
   always_comb begin
      case (wbReq.adr)
         OFS_FLAGS: rdByte = flagView;
         OFS_MASK: rdByte = mask_q;
         OFS_THR: rdByte = thr_q;
         OFS_PTR: rdByte = ptr_q & PTR_MASK;
         OFS_CTL: rdByte = {7'h00, hostMode_q};
         OFS_TOK: rdByte = tokView;
         OFS_ERRST: rdByte = REG_W'(errStat_q);
         OFS_ERREN: rdByte = REG_W'(errEn_q);
         default: rdByte = RST_VAL;
      endcase
   end

   // Bus slave
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
         datOut_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         datOut_q <= ack_d ? {24'h000000, rdByte} : '0;
         irq_q <= irq_d;
      end
   end

   // Software registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags_q <= RST_VAL;
         mask_q <= RST_VAL;
         thr_q <= RST_VAL;
         ptr_q <= RST_VAL;
         hostMode_q <= 1'b0;
         errStat_q <= '0;
         errEn_q <= '0;
      end else begin
         flags_q <= flags_d;
         mask_q <= wrMask ? wd : mask_q;
         thr_q <= wrThr ? wd : thr_q;
         ptr_q <= wrPtr ? (wd & PTR_MASK) : ptr_q;
         hostMode_q <= wrCtl ? wd[BIT_HOST] : hostMode_q;
         errStat_q <= errStat_d;
         errEn_q <= wrErrEn ? ERR_W'(wd) : errEn_q;
      end
   end

   // Line state timers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lsPrev_q <= LS_SE0;
         quietCnt_q <= '0;
         kCnt_q <= '0;
         idleCnt_q <= '0;
         se0Cnt_q <= '0;
         attached_q <= 1'b0;
         matchPrev_q <= 1'b0;
      end else begin
         lsPrev_q <= lineState;
         quietCnt_q <= stepCnt(~lsChanged, quietCnt_q, LINE_LIM);
         kCnt_q <= stepCnt(isK, kCnt_q, LINE_LIM);
         idleCnt_q <= stepCnt(isJ, idleCnt_q, IDLE_LIM);
         se0Cnt_q <= stepCnt(isSe0, se0Cnt_q, LINE_LIM);
         attached_q <= attached_d;
         matchPrev_q <= thrMatch;
      end
   end

   // Token queue
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         tokCount_q <= '0;
         tokFull_q <= 1'b0;
      end else begin
         wrPtr_q <= tokPush ? wrPtr_q + 1'b1 : wrPtr_q;
         rdPtr_q <= tokPop ? rdPtr_q + 1'b1 : rdPtr_q;
         tokCount_q <= tokCount_d;
         tokFull_q <= tokCount_d == TOK_FULL;
      end
   end

   always_ff @(posedge clk) begin
      if (tokPush)
         tokMem[wrPtr_q] <= tokenInfo;
   end

   assign wbAck = ack_q;
   assign wbDatOut = datOut_q;
   assign irq = irq_q;
   assign tokenFull = tokFull_q;
   assign hostModeEnable = hostMode_q;
   assign descTableBaseBits = ptr_q[7:1];

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence flagWrite(int b);
      wrFlags && wd[b] && !flagSet[b];
   endsequence

   sequence thrWrite;
      wrThr ##1 !wrThr;
   endsequence

   stall_set_a: assert property (stallHs |=> flags_q[BIT_STALL])
      else $error("stall flag not set");
   attach_set_a: assert property (attachHit |=> flags_q[BIT_ATTACH] && attached_q)
      else $error("attach flag not set");
   attach_qual_a: assert property ($rose(flags_q[BIT_ATTACH]) |-> $past(attachHit))
      else $error("attach flag set without qualified attach");
   resume_time_a: assert property ($rose(flags_q[BIT_RESUME]) |->
      $past(kCnt_q) == LINE_LIM - 1'b1)
      else $error("resume flag set before K held long enough");
   idle_time_a: assert property ($rose(flags_q[BIT_IDLE]) |->
      $past(idleCnt_q) == IDLE_LIM - 1'b1)
      else $error("idle flag set before idle held long enough");
   token_done_a: assert property (tokenDone && tokCount_q == '0 |=>
      flags_q[BIT_TOKEN] && tokView == {$past(tokenInfo), 2'h0})
      else $error("token flag or status wrong after token done");
   token_pop_a: assert property (tokPop && !tokPush |=>
      tokCount_q == $past(tokCount_q) - 1'b1)
      else $error("queue did not advance on token flag clear");
   frame_dev_a: assert property (!hostMode_q && sofRx |=> flags_q[BIT_FRAME])
      else $error("frame flag not set on SOF");
   frame_host_a: assert property (thrMatch && !matchPrev_q |=> flags_q[BIT_FRAME])
      else $error("frame flag not set at threshold");
   err_mask_a: assert property ((errEn_q == '0) [*2] |-> !flagView[BIT_ERR])
      else $error("error flag set by masked error");
   bus_rst_a: assert property (busRstHit |=> flags_q[BIT_RST])
      else $error("bus reset flag not set");
   detach_set_a: assert property (detachHit |=> flags_q[BIT_RST] && !attached_q)
      else $error("detach flag not set");
   thr_store_a: assert property (thrWrite |-> thr_q == $past(wd))
      else $error("threshold not stored");
   upper_zero_a: assert property (ack_q |-> datOut_q[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   flag_clear_a: assert property (flagWrite(BIT_STALL) |=> !flags_q[BIT_STALL])
      else $error("flag not cleared by write one");
   ptr_low_a: assert property (ptr_q[0] == 1'b0)
      else $error("pointer bit 0 set");
   err_readonly_a: assert property (errSum && !wrErrSt && !wrErrEn |=> flagView[BIT_ERR])
      else $error("error flag dropped without error status clear");
   irq_level_a: assert property (|(flagView & mask_q) |=> irq_q)
      else $error("interrupt not raised for unmasked flag");
endmodule

// file: verification/uef_cable_model.sv
/*
 Far-side cable model: shows the commanded USB line state.
 Assumes the bench picks J, K or SE0 for each scenario.
*/
`timescale 1ns/1ns
module uef_cable_model
   import uef_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [1:0] lineCmd,
   output logic [1:0] lineState
);
   // Line idles at J, commanded state held until changed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lineState <= LS_J;
      end else begin
         lineState <= lineCmd;
      end
   end
endmodule

// file: verification/usb_event_flags_sof_threshold_test.sv
/*
 Self-checking bench for the USB event flag block.
 Assumes the Wishbone answer timing and register map of the block.
*/
`timescale 1ns/1ns
module usb_event_flags_sof_threshold_test;
   import uef_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   uef_wbreq_s wbReq = '0;
   logic wbAck, irq, tokenFull, hostModeEnable;
   logic [DAT_W-1:0] wbDatOut;
   logic [DAT_W-1:0] rdat;
   logic [1:0] lineCmd = LS_J;
   logic [1:0] lineState;
   logic stallHs = 1'b0;
   logic tokenDone = 1'b0;
   logic sofRx = 1'b0;
   uef_tok_s tokenInfo = '0;
   logic [FRAME_W-1:0] frameLeft = 16'h00FF;
   logic [7:0] errEvent = 8'h00;
   logic [6:0] descTableBaseBits;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   always #25 clk = ~clk;
   uef_cable_model cable (.clk(clk), .nrst(nrst), .lineCmd(lineCmd), .lineState(lineState));
   uef_top #(.IDLE_CYCLES(200)) dut (.clk(clk), .nrst(nrst), .wbReq(wbReq), .wbAck(wbAck),
      .wbDatOut(wbDatOut), .irq(irq), .lineState(lineState), .stallHs(stallHs),
      .tokenDone(tokenDone), .tokenInfo(tokenInfo), .tokenFull(tokenFull), .sofRx(sofRx),
      .frameLeft(frameLeft), .errEvent(errEvent), .hostModeEnable(hostModeEnable),
      .descTableBaseBits(descTableBaseBits));
   task automatic close_out();
      $display("Counts: %0d compared, %0d mismatched", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         close_out();
      end
   end
   task automatic chk32(input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic chk1(input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   // Classic cycle: hold until ack sampled, then release
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
      do begin
         @(posedge clk);
      end while (wbAck !== 1'b1);
      rdat = wbDatOut;
      wbReq <= '0;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      wb(1'b1, adr, dat);
   endtask
   task automatic rd(input logic [7:0] adr, input logic [31:0] msk, output logic [31:0] val);
      wb(1'b0, adr, 32'h0);
      val = rdat & msk;
   endtask
   task automatic t_reset();
      logic [31:0] v;
      rd(OFS_FLAGS, 32'hFFFFFFFF, v);
      chk32(32'h0, v);
      rd(OFS_THR, 32'hFFFFFFFF, v);
      chk32(32'h0, v);
      rd(OFS_PTR, 32'hFFFFFFFF, v);
      chk32(32'h0, v);
      chk1(1'b0, irq);
      $display("test reset done");
   endtask
   task automatic t_regs();
      logic [31:0] v;
      wr(OFS_THR, 32'hFFFFFF4A);
      rd(OFS_THR, 32'hFFFFFFFF, v);
      chk32(32'h4A, v);
      wr(OFS_THR, 32'h12);
      rd(OFS_THR, 32'hFFFFFFFF, v);
      chk32(32'h12, v);
      wr(OFS_PTR, 32'hFFFFFFFF);
      rd(OFS_PTR, 32'hFFFFFFFF, v);
      chk32(32'hFE, v);
      chk32(32'h7F, {25'h0, descTableBaseBits});
      wr(8'h40, 32'hFF);
      rd(8'h40, 32'hFFFFFFFF, v);
      chk32(32'h0, v);
      $display("test registers done");
   endtask
   task automatic t_stall();
      logic [31:0] v;
      wr(OFS_FLAGS, 32'hFF);
      wr(OFS_MASK, 32'h80);
      @(posedge clk);
      stallHs <= 1'b1;
      @(posedge clk);
      stallHs <= 1'b0;
      repeat (2) @(posedge clk);
      chk1(1'b1, irq);
      rd(OFS_FLAGS, 32'h80, v);
      chk32(32'h80, v);
      wr(OFS_FLAGS, 32'h80);
      repeat (2) @(posedge clk);
      chk1(1'b0, irq);
      wr(OFS_MASK, 32'h0);
      $display("test stall done");
   endtask
   task automatic push(input logic [5:0] info);
      @(posedge clk);
      tokenDone <= 1'b1;
      tokenInfo <= info;
      @(posedge clk);
      tokenDone <= 1'b0;
   endtask
   task automatic t_token();
      logic [31:0] v;
      push(6'b0011_1_0);
      push(6'b1001_0_1);
      rd(OFS_TOK, 32'hFF, v);
      chk32(32'h38, v);
      rd(OFS_FLAGS, 32'h08, v);
      chk32(32'h08, v);
      wr(OFS_FLAGS, 32'h08);
      rd(OFS_TOK, 32'hFF, v);
      chk32(32'h94, v);
      rd(OFS_FLAGS, 32'h08, v);
      chk32(32'h08, v);
      wr(OFS_FLAGS, 32'h08);
      rd(OFS_TOK, 32'hFF, v);
      chk32(32'h0, v);
      $display("test token done");
   endtask
   task automatic t_full();
      logic [31:0] v;
      repeat (5) push(6'h2A);
      chk1(1'b1, tokenFull);
      repeat (4) begin
         rd(OFS_FLAGS, 32'h08, v);
         chk32(32'h08, v);
         wr(OFS_FLAGS, 32'h08);
      end
      rd(OFS_FLAGS, 32'h08, v);
      chk32(32'h0, v);
      chk1(1'b0, tokenFull);
      $display("test queue full done");
   endtask
   task automatic t_err();
      logic [31:0] v;
      @(posedge clk);
      errEvent <= 8'h04;
      @(posedge clk);
      errEvent <= 8'h00;
      rd(OFS_FLAGS, 32'h02, v);
      chk32(32'h0, v);
      wr(OFS_ERREN, 32'h04);
      rd(OFS_FLAGS, 32'h02, v);
      chk32(32'h02, v);
      wr(OFS_FLAGS, 32'h02);
      rd(OFS_FLAGS, 32'h02, v);
      chk32(32'h02, v);
      wr(OFS_ERRST, 32'h04);
      rd(OFS_FLAGS, 32'h02, v);
      chk32(32'h0, v);
      wr(OFS_ERREN, 32'h0);
      $display("test error done");
   endtask
   task automatic t_sof();
      logic [31:0] v;
      @(posedge clk);
      sofRx <= 1'b1;
      @(posedge clk);
      sofRx <= 1'b0;
      rd(OFS_FLAGS, 32'h04, v);
      chk32(32'h04, v);
      wr(OFS_THR, 32'h05);
      wr(OFS_CTL, 32'h01);
      wr(OFS_FLAGS, 32'hFF);
      chk1(1'b1, hostModeEnable);
      frameLeft <= 16'h0005;
      rd(OFS_FLAGS, 32'h04, v);
      chk32(32'h04, v);
      wr(OFS_CTL, 32'h0);
      frameLeft <= 16'h00FF;
      $display("test frame start done");
   endtask
   task automatic hold(input logic [1:0] st, input int n, input logic [31:0] msk,
         input logic [31:0] exp);
      logic [31:0] v;
      wr(OFS_FLAGS, 32'hFF);
      lineCmd <= st;
      repeat (n) @(posedge clk);
      rd(OFS_FLAGS, msk, v);
      chk32(exp, v);
   endtask
   task automatic t_line();
      hold(LS_K, 60, 32'h20, 32'h20);
      hold(LS_J, 220, 32'h10, 32'h10);
      hold(LS_SE0, 60, 32'h01, 32'h01);
      wr(OFS_CTL, 32'h01);
      hold(LS_J, 60, 32'h40, 32'h40);
      hold(LS_SE0, 60, 32'h41, 32'h01);
      hold(LS_SE0, 60, 32'h40, 32'h0);
      $display("test line done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_regs();
      t_stall();
      t_token();
      t_full();
      t_err();
      t_sof();
      t_line();
      close_out();
   end
endmodule
